// ### verilog/rfsr_cfg.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef RFSR_CFG_SVH
`define RFSR_CFG_SVH
`define RFSR_REG_STATUS 7'h44
`define RFSR_REG_STRENGTH 7'h45
`define RFSR_REG_FUNC 7'h46
`define RFSR_BIT_FULL 6
`define RFSR_BIT_NONEMPTY 5
`define RFSR_BIT_LEVEL 4
`define RFSR_BIT_OVERRUN 3
`define RFSR_BIT_FLUSH 2
`define RFSR_BIT_HALT 6
`define RFSR_BIT_TEST 5
`define RFSR_BIT_FAST 2
`define RFSR_STATUS_RSV_RST 2'h0
`define RFSR_FUNC_RST 8'h00
`define RFSR_ST_PUP 3'h0
`define RFSR_ST_SLEEP 3'h1
`define RFSR_ST_STBY 3'h2
`define RFSR_ST_TUNE 3'h3
`define RFSR_ST_RX 3'h4
`define RFSR_ST_EEPROM 3'h5
`define RFSR_MODE_DIRECT 2'h0
`define RFSR_MODE_BUFFER 2'h1
`define RFSR_MODE_PACKET 2'h2
`define RFSR_BUF_DEPTH 6'h20
`define RFSR_PIN_RST 3'h4
`define RFSR_CLK_NS 100
`define RFSR_FILT_STEP_NS 1600
`define RFSR_FILT_DIV ((`RFSR_FILT_STEP_NS) / (`RFSR_CLK_NS))
`endif

// ### verilog/rfsr_pkg.sv
// Types shared by the register group and its submodules.
package rfsr_pkg;
  typedef enum logic [1:0] {SPI_ADDR, SPI_DATA, SPI_DONE} rfsr_spi_e;
  typedef logic [7:0] rfsr_byte_t;
  typedef logic [2:0] rfsr_opstate_t;
endpackage

// ### verilog/rfsr_spi_port.sv
// Four-wire serial port slave: address byte, then one data byte.
`timescale 1ns/1ps
`default_nettype none
`include "rfsr_cfg.svh"
module rfsr_spi_port import rfsr_pkg::*; (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Pins.
  input wire logic csn_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // Register side.
  input wire rfsr_byte_t rdata_in,
  output logic [6:0] addr_out,
  output rfsr_byte_t wdata_out,
  output logic wr_out
);
  logic [2:0] pin_raw;
  logic [2:0] pin_st;
  assign pin_raw = {csn_in, sclk_in, mosi_in};
  // Idle levels of the three pins, so no false edge follows reset.
  localparam logic [2:0] pin_rst_c = `RFSR_PIN_RST;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic s1_q, s2_q, s3_q, st_q, st_d;
      always_comb begin
        st_d = (s2_q == s3_q) ? s3_q : st_q;
      end
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          s1_q <= pin_rst_c[g];
          s2_q <= pin_rst_c[g];
          s3_q <= pin_rst_c[g];
          st_q <= pin_rst_c[g];
        end else begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          st_q <= st_d;
        end
      end
      assign pin_st[g] = st_q;
    end
  endgenerate
  rfsr_spi_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  rfsr_byte_t sh_q, sh_d, tx_q, tx_d, wd_q, wd_d, byte_in;
  logic [6:0] addr_q, addr_d;
  logic sclk_q, rd_q, rd_d, ld_q, ld_d, wr_q, wr_d, oe_q, oe_d, rise, fall;
  assign rise = pin_st[1] & ~sclk_q;
  assign fall = ~pin_st[1] & sclk_q;
  assign byte_in = {sh_q[6:0], pin_st[0]};
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    wd_d = wd_q;
    addr_d = addr_q;
    rd_d = rd_q;
    ld_d = 1'b0;
    wr_d = 1'b0;
    oe_d = oe_q;
    if (pin_st[2]) begin
      st_d = SPI_ADDR;
      cnt_d = 3'h0;
      oe_d = 1'b0;
    end else begin
      if (rise) begin
        sh_d = byte_in;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          case (st_q)
            SPI_ADDR: begin
              rd_d = byte_in[7];
              addr_d = byte_in[6:0];
              ld_d = 1'b1;
              oe_d = byte_in[7];
              st_d = SPI_DATA;
            end
            SPI_DATA: begin
              wr_d = ~rd_q;
              wd_d = byte_in;
              oe_d = 1'b0;
              st_d = SPI_DONE;
            end
            default: st_d = SPI_DONE;
          endcase
        end
      end
      if (fall && cnt_q != 3'h0) begin
        tx_d = {tx_q[6:0], 1'b0};
      end
      if (ld_q) begin
        tx_d = rdata_in;
      end
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= SPI_ADDR;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      wd_q <= 8'h00;
      addr_q <= 7'h00;
      rd_q <= 1'b0;
      ld_q <= 1'b0;
      wr_q <= 1'b0;
      oe_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      wd_q <= wd_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      ld_q <= ld_d;
      wr_q <= wr_d;
      oe_q <= oe_d;
      sclk_q <= pin_st[1];
    end
  end
  assign miso_out = tx_q[7];
  assign miso_oe_out = oe_q;
  assign addr_out = addr_q;
  assign wdata_out = wd_q;
  assign wr_out = wr_q;
endmodule // rfsr_spi_port
`default_nettype wire

// ### verilog/rfsr_rx_buffer.sv
// Receive byte buffer, 32 deep, with flush and overrun tracking.
`timescale 1ns/1ps
`default_nettype none
`include "rfsr_cfg.svh"
module rfsr_rx_buffer import rfsr_pkg::*; (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Control and data.
  input wire logic flush_in,
  input wire logic wr_in,
  input wire rfsr_byte_t wdata_in,
  input wire logic rd_in,
  output rfsr_byte_t rdata_out,
  output logic [5:0] count_out,
  output logic overrun_out,
  output logic strobe_out
);
  rfsr_byte_t mem [0:31];
  rfsr_byte_t rdata_q, rdata_d;
  logic [4:0] wp_q, wp_d, rp_q, rp_d;
  logic [5:0] cnt_q, cnt_d;
  logic ovr_q, ovr_d, we, do_rd, full;
  always_comb begin
    full = (cnt_q == `RFSR_BUF_DEPTH);
    do_rd = rd_in && (cnt_q != 6'h00) && !flush_in;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    ovr_d = ovr_q;
    rdata_d = rdata_q;
    we = 1'b0;
    if (flush_in) begin
      // A byte arriving with the flush is kept as the first new byte.
      rp_d = 5'h00;
      ovr_d = 1'b0;
      we = wr_in;
      wp_d = {4'h0, wr_in};
      cnt_d = {5'h00, wr_in};
    end else begin
      if (do_rd) begin
        rdata_d = mem[rp_q];
        rp_d = rp_q + 5'h01;
      end
      if (wr_in && full && !do_rd) begin
        ovr_d = 1'b1;
      end else if (wr_in) begin
        we = 1'b1;
        wp_d = wp_q + 5'h01;
      end else if (do_rd) begin
        ovr_d = 1'b0;
      end
      cnt_d = cnt_q + {5'h00, we} - {5'h00, do_rd};
    end
  end
  always_ff @(posedge mclk_in) begin
    if (we) begin
      mem[flush_in ? 5'h00 : wp_q] <= wdata_in;
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
      cnt_q <= 6'h00;
      ovr_q <= 1'b0;
      rdata_q <= 8'h00;
      strobe_out <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ovr_q <= ovr_d;
      rdata_q <= rdata_d;
      strobe_out <= we;
    end
  end
  assign rdata_out = rdata_q;
  assign count_out = cnt_q;
  assign overrun_out = ovr_q;
endmodule // rfsr_rx_buffer
`default_nettype wire

// ### verilog/rfsr_regs.sv
// Buffer status, signal strength and function enable register group.
`timescale 1ns/1ps
`default_nettype none
`include "rfsr_cfg.svh"
module rfsr_regs import rfsr_pkg::*; (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Serial configuration port.
  input wire logic csn_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // Chip state and configuration.
  input wire rfsr_opstate_t op_state_in,
  input wire logic [1:0] data_mode_in,
  input wire logic [5:0] buf_threshold_in,
  input wire rfsr_byte_t squelch_thresh_in,
  // Receive data path.
  input wire logic rx_byte_valid_in,
  input wire rfsr_byte_t rx_byte_in,
  input wire logic buf_rd_in,
  output rfsr_byte_t buf_rdata_out,
  output logic byte_write_strobe_out,
  output logic pkt_handler_reset_out,
  // Signal strength.
  input wire rfsr_byte_t strength_raw_in,
  output rfsr_byte_t signal_strength_reading_out,
  // Buffer flags.
  output logic buffer_full_indicator_out,
  output logic buffer_nonempty_indicator_out,
  output logic buffer_level_indicator_out,
  output logic buffer_overrun_indicator_out,
  // Function enables.
  output logic sleep_timer_halt_out,
  output logic factory_test_enable_out,
  output logic fast_serial_enable_out
);

  //////////////////////////////////////////////////////////////////////////

  function automatic logic reg_hit(input logic [6:0] a, input logic [6:0] o);
    reg_hit = (a == o);
  endfunction

  logic [6:0] bus_addr;
  rfsr_byte_t bus_wdata;
  rfsr_byte_t bus_rdata;
  logic bus_wr;

  rfsr_spi_port u_spi (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .csn_in(csn_in),
    .sclk_in(sclk_in),
    .mosi_in(mosi_in),
    .miso_out(miso_out),
    .miso_oe_out(miso_oe_out),
    .rdata_in(bus_rdata),
    .addr_out(bus_addr),
    .wdata_out(bus_wdata),
    .wr_out(bus_wr)
  );

  //////////////////////////////////////////////////////////////////////////

  logic wr_status;
  logic wr_func;
  logic in_sleep;
  logic flush_ok;
  logic flush;

  always_comb begin
    wr_status = bus_wr && reg_hit(bus_addr, `RFSR_REG_STATUS);
    wr_func = bus_wr && reg_hit(bus_addr, `RFSR_REG_FUNC);
    in_sleep = (op_state_in == `RFSR_ST_SLEEP);
    flush_ok = 1'b0;
    case (op_state_in)
      `RFSR_ST_STBY: flush_ok = 1'b1;
      `RFSR_ST_TUNE: flush_ok = 1'b1;
      `RFSR_ST_RX: flush_ok = 1'b1;
      `RFSR_ST_EEPROM: flush_ok = 1'b1;
      default: flush_ok = 1'b0;
    endcase
    // Sleep flushes the buffer on every cycle the chip stays there; a byte arriving with a flush is kept as the first new byte.
    flush = in_sleep ||
      (wr_status && bus_wdata[`RFSR_BIT_FLUSH] && flush_ok);
  end

  //////////////////////////////////////////////////////////////////////////

  rfsr_byte_t buf_rdata;
  logic [5:0] buf_count;
  logic buf_overrun;
  logic buf_strobe;

  rfsr_rx_buffer u_buf (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .flush_in(flush),
    .wr_in(rx_byte_valid_in),
    .wdata_in(rx_byte_in),
    .rd_in(buf_rd_in),
    .rdata_out(buf_rdata),
    .count_out(buf_count),
    .overrun_out(buf_overrun),
    .strobe_out(buf_strobe)
  );

  assign buf_rdata_out = buf_rdata;
  assign byte_write_strobe_out = buf_strobe;

  //////////////////////////////////////////////////////////////////////////

  logic [3:0] flags_q, flags_d;
  logic [1:0] rsv_q, rsv_d;
  rfsr_byte_t func_q, func_d;
  logic phr_q, phr_d;
  logic flag_mode;

  always_comb begin
    flag_mode = (data_mode_in == `RFSR_MODE_BUFFER) ||
      (data_mode_in == `RFSR_MODE_PACKET);
    flags_d = 4'h0;
    if (flag_mode) begin
      flags_d[3] = (buf_count == `RFSR_BUF_DEPTH);
      flags_d[2] = (buf_count != 6'h00);
      flags_d[1] = (buf_count >= buf_threshold_in);
      flags_d[0] = buf_overrun;
    end
    rsv_d = rsv_q;
    func_d = func_q;
    // Reserved bits are stored as written so a read returns them.
    if (wr_status) begin
      rsv_d = bus_wdata[1:0];
    end
    if (wr_func) begin
      func_d = bus_wdata;
    end
    phr_d = in_sleep;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q <= 4'h0;
      rsv_q <= `RFSR_STATUS_RSV_RST;
      func_q <= `RFSR_FUNC_RST;
      phr_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      rsv_q <= rsv_d;
      func_q <= func_d;
      phr_q <= phr_d;
    end
  end

  assign buffer_full_indicator_out = flags_q[3];
  assign buffer_nonempty_indicator_out = flags_q[2];
  assign buffer_level_indicator_out = flags_q[1];
  assign buffer_overrun_indicator_out = flags_q[0];
  assign pkt_handler_reset_out = phr_q;
  assign sleep_timer_halt_out = func_q[`RFSR_BIT_HALT];
  assign factory_test_enable_out = func_q[`RFSR_BIT_TEST];
  assign fast_serial_enable_out = func_q[`RFSR_BIT_FAST];

  //////////////////////////////////////////////////////////////////////////

  // Filter: acc holds four times the average; each step moves a quarter.
  logic [3:0] div_q, div_d;
  logic [9:0] acc_q, acc_d;
  rfsr_byte_t str_q, str_d;
  logic step;
  rfsr_byte_t filt;

  always_comb begin
    step = (div_q == 4'(`RFSR_FILT_DIV - 1));
    div_d = step ? 4'h0 : div_q + 4'h1;
    acc_d = acc_q;
    str_d = str_q;
    filt = acc_q[9:2];
    if (step && op_state_in == `RFSR_ST_RX) begin
      acc_d = acc_q - {2'h0, acc_q[9:2]} + {2'h0, strength_raw_in};
      str_d = (filt < squelch_thresh_in) ? 8'h00 : filt;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 4'h0;
      acc_q <= 10'h000;
      str_q <= 8'h00;
    end else begin
      div_q <= div_d;
      acc_q <= acc_d;
      str_q <= str_d;
    end
  end

  assign signal_strength_reading_out = str_q;

  //////////////////////////////////////////////////////////////////////////

  // Read data is chosen from the latched address of the current frame.
  always_comb begin
    case (bus_addr)
      `RFSR_REG_STATUS: begin
        bus_rdata = {1'b0, flags_q, 1'b0, rsv_q};
      end
      `RFSR_REG_STRENGTH: bus_rdata = str_q;
      `RFSR_REG_FUNC: bus_rdata = func_q;
      default: bus_rdata = 8'h00;
    endcase
  end

endmodule // rfsr_regs
`default_nettype wire

// ### dv/rfsr_regs_assertions.sv
// Concurrent checks on the ports of the buffer status register group.
`timescale 1ns/1ps
`default_nettype none
`include "rfsr_cfg.svh"
module rfsr_regs_assertions import rfsr_pkg::*; (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Block inputs.
  input wire logic csn_in,
  input wire rfsr_opstate_t op_state_in,
  input wire logic [1:0] data_mode_in,
  input wire rfsr_byte_t squelch_thresh_in,
  input wire logic rx_byte_valid_in,
  // Block outputs.
  input wire logic byte_write_strobe_out,
  input wire logic pkt_handler_reset_out,
  input wire rfsr_byte_t signal_strength_reading_out,
  input wire logic buffer_full_indicator_out,
  input wire logic buffer_nonempty_indicator_out,
  input wire logic buffer_level_indicator_out,
  input wire logic buffer_overrun_indicator_out,
  input wire logic sleep_timer_halt_out,
  input wire logic factory_test_enable_out,
  input wire logic fast_serial_enable_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] flags;
  assign flags = {buffer_full_indicator_out, buffer_nonempty_indicator_out,
    buffer_level_indicator_out, buffer_overrun_indicator_out};
  sequence s_byte_in;
    rx_byte_valid_in && !buffer_full_indicator_out &&
      op_state_in != `RFSR_ST_SLEEP;
  endsequence
  sequence s_asleep;
    (op_state_in == `RFSR_ST_SLEEP) [*3];
  endsequence
  chk_direct_quiet: assert property (
    (data_mode_in == `RFSR_MODE_DIRECT) [*3] |-> flags == 4'h0)
    else $error("buffer flag set in direct mode");
  chk_full_nonempty: assert property (
    buffer_full_indicator_out |-> buffer_nonempty_indicator_out)
    else $error("full without nonempty");
  chk_overrun_full: assert property (
    buffer_overrun_indicator_out |-> buffer_full_indicator_out)
    else $error("overrun without full");
  chk_strobe_follows: assert property (
    s_byte_in |-> ##[1:2] byte_write_strobe_out)
    else $error("no strobe for stored byte");
  chk_strobe_cause: assert property (
    byte_write_strobe_out |->
      $past(rx_byte_valid_in) || $past(rx_byte_valid_in, 2))
    else $error("strobe without byte");
  chk_sleep_empty: assert property (
    s_asleep |-> pkt_handler_reset_out && flags == 4'h0)
    else $error("sleep did not clear buffer");
  chk_handler_release: assert property (
    (op_state_in != `RFSR_ST_SLEEP) [*2] |-> !pkt_handler_reset_out)
    else $error("handler reset outside sleep");
  chk_strength_hold: assert property (
    $past(op_state_in) != `RFSR_ST_RX &&
      $past(op_state_in, 2) != `RFSR_ST_RX |->
      $stable(signal_strength_reading_out))
    else $error("strength moved outside receive");
  chk_squelch_mask: assert property (
    signal_strength_reading_out != 8'h00 && $stable(squelch_thresh_in) |->
      signal_strength_reading_out >= squelch_thresh_in)
    else $error("strength below squelch shown");
  chk_func_frame: assert property (
    $changed({sleep_timer_halt_out, factory_test_enable_out,
      fast_serial_enable_out}) |-> !$past(csn_in, 2))
    else $error("function bit moved outside frame");
endmodule // rfsr_regs_assertions
////////////////////////////////////////////////////////////////////////////
bind rfsr_regs rfsr_regs_assertions i_chk (.mclk_in, .rst_in, .csn_in,
  .op_state_in, .data_mode_in, .squelch_thresh_in, .rx_byte_valid_in,
  .byte_write_strobe_out, .pkt_handler_reset_out,
  .signal_strength_reading_out, .buffer_full_indicator_out,
  .buffer_nonempty_indicator_out, .buffer_level_indicator_out,
  .buffer_overrun_indicator_out, .sleep_timer_halt_out,
  .factory_test_enable_out, .fast_serial_enable_out);
`default_nettype wire

// ### dv/rfsr_host_model.sv
// Host controller model driving the four-wire serial configuration port.
`timescale 1ns/1ps
`default_nettype none
`include "rfsr_cfg.svh"
module rfsr_host_model import rfsr_pkg::*; (
  // Clock.
  input wire logic mclk_in,
  // Serial pins.
  output logic csn_out,
  output logic sclk_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial begin
    csn_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // A half period of 13 clocks stays under 400 kHz; 5 clocks gives 1 MHz.
  task automatic xfer(input logic rw, input logic [6:0] a,
    input rfsr_byte_t d, output rfsr_byte_t q, input logic fast);
    logic [15:0] sh;
    int h;
    h = fast ? 5 : 13;
    if (a == `RFSR_REG_STATUS) d[1:0] = 2'h0;
    if (a == `RFSR_REG_FUNC) d = d & 8'h64;
    sh = {rw, a, d};
    q = 8'h00;
    @(negedge mclk_in);
    csn_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = sh[i];
      repeat (h) @(negedge mclk_in);
      sclk_out = 1'b1;
      q = {q[6:0], miso_in};
      repeat (h) @(negedge mclk_in);
      sclk_out = 1'b0;
    end
    repeat (h) @(negedge mclk_in);
    csn_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (h) @(negedge mclk_in);
  endtask
endmodule // rfsr_host_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking testbench for the buffer status register group.
`timescale 1ns/1ps
`default_nettype none
`include "rfsr_cfg.svh"
module testbench import rfsr_pkg::*;;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic csn_in, sclk_in, mosi_in, miso_out, miso_oe_out;
  logic miso_last = 1'b0;
  rfsr_opstate_t op_state_in = `RFSR_ST_STBY;
  logic [1:0] data_mode_in = `RFSR_MODE_BUFFER;
  logic [5:0] buf_threshold_in = 6'h03;
  rfsr_byte_t squelch_thresh_in = 8'h00;
  rfsr_byte_t rx_byte_in = 8'h00;
  rfsr_byte_t strength_raw_in = 8'h00;
  logic rx_byte_valid_in = 1'b0;
  logic buf_rd_in = 1'b0;
  rfsr_byte_t buf_rdata_out, signal_strength_reading_out, q;
  logic byte_write_strobe_out, pkt_handler_reset_out;
  logic buffer_full_indicator_out, buffer_nonempty_indicator_out;
  logic buffer_level_indicator_out, buffer_overrun_indicator_out;
  logic sleep_timer_halt_out, factory_test_enable_out, fast_serial_enable_out;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int strobes = 0;
  // A released data line shows the inverse of its last driven level.
  wire logic miso_line = miso_oe_out ? miso_out : ~miso_last;
  rfsr_regs i_dut (.mclk_in, .rst_in, .csn_in, .sclk_in, .mosi_in,
    .miso_out, .miso_oe_out, .op_state_in, .data_mode_in,
    .buf_threshold_in, .squelch_thresh_in, .rx_byte_valid_in, .rx_byte_in,
    .buf_rd_in, .buf_rdata_out, .byte_write_strobe_out,
    .pkt_handler_reset_out, .strength_raw_in, .signal_strength_reading_out,
    .buffer_full_indicator_out, .buffer_nonempty_indicator_out,
    .buffer_level_indicator_out, .buffer_overrun_indicator_out,
    .sleep_timer_halt_out, .factory_test_enable_out, .fast_serial_enable_out);
  rfsr_host_model i_host (.mclk_in, .csn_out(csn_in), .sclk_out(sclk_in),
    .mosi_out(mosi_in), .miso_in(miso_line));
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (miso_oe_out === 1'b1) miso_last <= miso_out;
    if (byte_write_strobe_out === 1'b1) strobes <= strobes + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h not %h", $time, what, seen,
        exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] flg();
    return {4'h0, buffer_full_indicator_out, buffer_nonempty_indicator_out,
      buffer_level_indicator_out, buffer_overrun_indicator_out};
  endfunction
  function automatic logic [7:0] fen();
    return {5'h00, sleep_timer_halt_out, factory_test_enable_out,
      fast_serial_enable_out};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic rd(input logic [6:0] a);
    i_host.xfer(1'b1, a, 8'h00, q, 1'b0);
  endtask
  task automatic wr(input logic [6:0] a, input rfsr_byte_t d, input logic f);
    rfsr_byte_t unused;
    i_host.xfer(1'b0, a, d, unused, f);
  endtask
  task automatic push(input rfsr_byte_t b);
    @(negedge mclk_in);
    rx_byte_in = b;
    rx_byte_valid_in = 1'b1;
    @(negedge mclk_in);
    rx_byte_valid_in = 1'b0;
    cyc(3);
  endtask
  task automatic t_reset();
    rd(`RFSR_REG_FUNC);
    check(q, `RFSR_FUNC_RST, "func reset");
    rd(`RFSR_REG_STATUS);
    check(q, 8'h00, "status reset");
    rd(7'h50);
    check(q, 8'h00, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_func();
    wr(`RFSR_REG_FUNC, 8'h64, 1'b0);
    check(fen(), 8'h07, "func set");
    rd(`RFSR_REG_FUNC);
    check(q, 8'h64, "func read");
    wr(`RFSR_REG_FUNC, 8'h20, 1'b1);
    check(fen(), 8'h02, "fast frame");
    wr(`RFSR_REG_FUNC, 8'h00, 1'b0);
    check(fen(), 8'h00, "func clear");
    $display("test func done");
  endtask
  task automatic t_fill();
    logic [3:0] e;
    for (int i = 0; i < 33; i++) begin
      push(8'h10 + 8'(i));
      e = {i >= 31, 1'b1, i >= 2, i == 32};
      check(flg(), {4'h0, e}, "fill flags");
    end
    check(8'(strobes), 8'h20, "strobes");
    rd(`RFSR_REG_STATUS);
    check(q, 8'h78, "status full");
    @(negedge mclk_in);
    buf_rd_in = 1'b1;
    @(negedge mclk_in);
    buf_rd_in = 1'b0;
    cyc(3);
    check(buf_rdata_out, 8'h10, "first byte");
    check(flg(), 8'h06, "after pop");
    wr(`RFSR_REG_STATUS, 8'h07, 1'b0);
    check(flg(), 8'h00, "flush");
    push(8'h55);
    wr(`RFSR_REG_STATUS, 8'h00, 1'b0);
    check(flg(), 8'h04, "write zero");
    $display("test fill done");
  endtask
  task automatic t_state();
    rfsr_opstate_t st[5] = '{`RFSR_ST_PUP, `RFSR_ST_STBY, `RFSR_ST_TUNE,
      `RFSR_ST_RX, `RFSR_ST_EEPROM};
    foreach (st[i]) begin
      op_state_in = st[i];
      push(8'h20);
      wr(`RFSR_REG_STATUS, 8'h04, 1'b0);
      check(flg() & 8'h04, (i == 0) ? 8'h04 : 8'h00, "state flush");
    end
    op_state_in = `RFSR_ST_PUP;
    push(8'h21);
    op_state_in = `RFSR_ST_SLEEP;
    cyc(4);
    check(flg(), 8'h00, "sleep empties");
    check({7'h00, pkt_handler_reset_out}, 8'h01, "handler reset");
    op_state_in = `RFSR_ST_STBY;
    cyc(3);
    check({7'h00, pkt_handler_reset_out}, 8'h00, "handler release");
    push(8'h30);
    push(8'h31);
    data_mode_in = `RFSR_MODE_DIRECT;
    cyc(3);
    check(flg(), 8'h00, "direct mode");
    data_mode_in = `RFSR_MODE_PACKET;
    cyc(3);
    check(flg(), 8'h04, "packet mode");
    wr(`RFSR_REG_STATUS, 8'h04, 1'b0);
    $display("test state done");
  endtask
  task automatic t_strength();
    op_state_in = `RFSR_ST_RX;
    strength_raw_in = 8'hC8;
    cyc(1000);
    check(signal_strength_reading_out, 8'hC8, "settled");
    rd(`RFSR_REG_STRENGTH);
    check(q, 8'hC8, "strength read");
    strength_raw_in = 8'h00;
    cyc(16);
    check(8'(signal_strength_reading_out inside {8'h96, 8'hC8}), 8'h01,
      "filtered");
    squelch_thresh_in = 8'h96;
    strength_raw_in = 8'h64;
    cyc(1000);
    check(signal_strength_reading_out, 8'h00, "squelch");
    op_state_in = `RFSR_ST_STBY;
    cyc(20);
    squelch_thresh_in = 8'h00;
    cyc(100);
    check(signal_strength_reading_out, 8'h00, "hold");
    $display("test strength done");
  endtask
  initial begin
    cyc(3);
    rst_in = 1'b0;
    cyc(4);
    t_reset();
    t_func();
    t_fill();
    t_state();
    t_strength();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
